// File: core/rcs_sampler.sv
// Reset configuration sampler: captures the startup configuration word at hard
// reset release and holds the decoded startup settings.
// Assumes all inputs are synchronous to mclk_i, the system clock output.
`default_nettype none

// What this block does
// - The word is sampled on the last two system clock edges before hard reset release.
// - With the select input asserted the bus word is used, otherwise the internal default.
// - The word decodes into arbitration type, vector prefix, controller disable, port size and base.
// - A disabled memory controller keeps the chip-select machine and boot chip select off.
// - Writing the map base register after reset release relocates the register space like the captured base field.
module rcs_sampler #(
	parameter int CFG_W = rcs_pkg::CFG_W,
	parameter logic [31:0] DEFAULT_CFG = rcs_pkg::DEFAULT_CFG
) (
	// Clock and power-on reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Reset framing and configuration source
	input wire logic hard_reset_input_n_i,
	input wire logic reset_config_select_n_i,
	input wire logic [CFG_W-1:0] data_bus_i,
	// Internal map base register write port
	input wire logic map_base_wr_i,
	input wire logic [rcs_pkg::BASE_W-1:0] map_base_wdata_i,
	// Startup settings
	output logic cfg_valid_o,
	output logic cfg_mismatch_o,
	output logic arb_internal_o,
	output logic irq_prefix_o,
	output logic mc_disable_o,
	output logic gpcs_enable_o,
	output logic boot_chip_select_en_o,
	output logic [rcs_pkg::BPS_W-1:0] boot_port_size_o,
	output logic [rcs_pkg::BASE_W-1:0] internal_map_base_o
);

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	if (CFG_W != 32) begin : g_bad_width
		$error("rcs_sampler: configuration word must be 32 bits wide");
	end

	// ------------------------------------------------------------
	// Base field decode
	// ------------------------------------------------------------
	// Each base code selects the upper half of the register space address.
	function automatic logic [rcs_pkg::BASE_W-1:0] base_decode(
		input logic [rcs_pkg::SPACE_BASE_W-1:0] code
	);
		unique case (code)
			2'h0: base_decode = rcs_pkg::BASE_CODE0;
			2'h1: base_decode = rcs_pkg::BASE_CODE1;
			2'h2: base_decode = rcs_pkg::BASE_CODE2;
			2'h3: base_decode = rcs_pkg::BASE_CODE3;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Sampling during hard reset
	// ------------------------------------------------------------
	logic hr_prev_reg;
	logic [CFG_W:0] last_s;
	logic [CFG_W:0] prev_s;
	wire logic in_reset = ~hard_reset_input_n_i;
	wire logic release_w = hard_reset_input_n_i & ~hr_prev_reg;

	// Every edge inside hard reset is sampled, so the two held samples at
	// release are exactly the final two edges before it.
	rcs_capture #(
		.W(CFG_W + 1)
	) u_capture (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.en_i(in_reset),
		.d_i({~reset_config_select_n_i, data_bus_i}),
		.last_o(last_s),
		.prev_o(prev_s)
	);

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			hr_prev_reg <= 1'b0;
		end else begin
			hr_prev_reg <= hard_reset_input_n_i;
		end
	end

	// ------------------------------------------------------------
	// Source selection and field decode
	// ------------------------------------------------------------
	wire logic sel_bus = last_s[CFG_W];
	wire logic [31:0] word_w = sel_bus ? last_s[31:0] : DEFAULT_CFG;
	wire logic mismatch_w = (last_s != prev_s);
	wire logic mc_dis_w = word_w[rcs_pkg::MC_DIS_BIT];
	wire logic [rcs_pkg::BPS_W-1:0] bps_w =
		word_w[rcs_pkg::BPS_LSB +: rcs_pkg::BPS_W];
	wire logic [rcs_pkg::BASE_W-1:0] base_w =
		base_decode(word_w[rcs_pkg::SPACE_BASE_LSB +: rcs_pkg::SPACE_BASE_W]);
	wire logic [rcs_pkg::BASE_W-1:0] dflt_base =
		base_decode(DEFAULT_CFG[rcs_pkg::SPACE_BASE_LSB +: rcs_pkg::SPACE_BASE_W]);
	// A write that meets the release edge is dropped, so the freshly captured base wins.
	wire logic base_wr_w = map_base_wr_i & cfg_valid_o & hard_reset_input_n_i;

	// ------------------------------------------------------------
	// Startup settings, loaded once per reset release
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			cfg_valid_o <= 1'b0;
			cfg_mismatch_o <= 1'b0;
			arb_internal_o <= DEFAULT_CFG[rcs_pkg::ARB_BIT];
			irq_prefix_o <= DEFAULT_CFG[rcs_pkg::PREFIX_BIT];
			mc_disable_o <= DEFAULT_CFG[rcs_pkg::MC_DIS_BIT];
			gpcs_enable_o <= 1'b0;
			boot_chip_select_en_o <= 1'b0;
			boot_port_size_o <= DEFAULT_CFG[rcs_pkg::BPS_LSB +: rcs_pkg::BPS_W];
			internal_map_base_o <= dflt_base;
		end else if (in_reset) begin
			cfg_valid_o <= 1'b0;
			gpcs_enable_o <= 1'b0;
			boot_chip_select_en_o <= 1'b0;
		end else if (release_w) begin
			cfg_valid_o <= 1'b1;
			cfg_mismatch_o <= mismatch_w;
			arb_internal_o <= word_w[rcs_pkg::ARB_BIT];
			irq_prefix_o <= word_w[rcs_pkg::PREFIX_BIT];
			mc_disable_o <= mc_dis_w;
			gpcs_enable_o <= ~mc_dis_w;
			boot_chip_select_en_o <= ~mc_dis_w;
			boot_port_size_o <= bps_w;
			internal_map_base_o <= base_w;
		end else if (base_wr_w) begin
			// Only the base register may change after release.
			internal_map_base_o <= map_base_wdata_i;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sample_bus_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		release_w && last_s[CFG_W] && $past(in_reset, rcs_pkg::SAMPLE_EDGES)
		|=> cfg_valid_o && mc_disable_o == $past(last_s[rcs_pkg::MC_DIS_BIT])
		&& boot_port_size_o == $past(last_s[rcs_pkg::BPS_LSB +: rcs_pkg::BPS_W]))
		else $error("bus word not taken at reset release");

	default_src_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		release_w && !last_s[CFG_W]
		|=> mc_disable_o == DEFAULT_CFG[rcs_pkg::MC_DIS_BIT]
		&& irq_prefix_o == DEFAULT_CFG[rcs_pkg::PREFIX_BIT])
		else $error("default word not used without select");

	decode_base_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		release_w |=> internal_map_base_o == $past(base_w)
		&& arb_internal_o == $past(word_w[rcs_pkg::ARB_BIT]))
		else $error("startup field decode wrong");

	cs_disable_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cfg_valid_o |-> (gpcs_enable_o == !mc_disable_o)
		&& (boot_chip_select_en_o == !mc_disable_o))
		else $error("chip select enable disagrees with controller disable");

	base_write_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		base_wr_w && !release_w |=> internal_map_base_o == $past(map_base_wdata_i))
		else $error("map base write did not relocate");

	settings_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cfg_valid_o && hard_reset_input_n_i
		|=> cfg_valid_o && $stable(mc_disable_o) && $stable(irq_prefix_o)
		&& $stable(arb_internal_o) && $stable(boot_port_size_o))
		else $error("startup settings changed after release");

	// ------------------------------------------------------------
	// Checks on capture, refusal and hold
	// ------------------------------------------------------------
	// The capture stage must shift one sample per edge while hard reset is low.
	capture_shift_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		in_reset |=> last_s[CFG_W-1:0] == $past(data_bus_i)
		&& last_s[CFG_W] == !$past(reset_config_select_n_i)
		&& prev_s == $past(last_s))
		else $error("capture stage did not shift at a hard reset edge");

	mismatch_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		release_w |=> cfg_mismatch_o == ($past(last_s) != $past(prev_s)))
		else $error("unequal final samples not flagged");

	release_valid_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		release_w |=> cfg_valid_o)
		else $error("settings not marked valid after reset release");

	bus_flags_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		release_w && last_s[CFG_W]
		|=> irq_prefix_o == $past(last_s[rcs_pkg::PREFIX_BIT])
		&& arb_internal_o == $past(last_s[rcs_pkg::ARB_BIT]))
		else $error("arbitration or prefix bit not taken from the bus word");

	default_fields_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		release_w && !last_s[CFG_W]
		|=> arb_internal_o == DEFAULT_CFG[rcs_pkg::ARB_BIT]
		&& boot_port_size_o == DEFAULT_CFG[rcs_pkg::BPS_LSB +: rcs_pkg::BPS_W]
		&& internal_map_base_o == dflt_base)
		else $error("default word fields not loaded");

	// Before release the boot chip select must stay off whatever the word says.
	cs_held_off_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		!cfg_valid_o |-> !gpcs_enable_o && !boot_chip_select_en_o)
		else $error("chip select enabled before configuration release");

	valid_drop_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		in_reset |=> !cfg_valid_o)
		else $error("settings still marked valid inside hard reset");

	base_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		in_reset |=> $stable(internal_map_base_o))
		else $error("map base changed inside hard reset");

	base_refused_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		map_base_wr_i && !cfg_valid_o && !release_w |=> $stable(internal_map_base_o))
		else $error("map base write taken before release");

endmodule

`default_nettype wire

// File: core/rcs_pkg.sv
// Package for the reset configuration sampler: word layout, defaults and widths.
// Assumes a 32-bit configuration word presented on the external data bus.
`default_nettype none

package rcs_pkg;

	// ------------------------------------------------------------
	// Configuration word layout
	// ------------------------------------------------------------
	localparam int CFG_W = 32;
	localparam int ARB_BIT = 31;
	localparam int PREFIX_BIT = 30;
	localparam int MC_DIS_BIT = 29;
	localparam int BPS_LSB = 27;
	localparam int BPS_W = 2;
	localparam int SPACE_BASE_LSB = 25;
	localparam int SPACE_BASE_W = 2;
	localparam int BASE_W = 16;

	// ------------------------------------------------------------
	// Internal default word and base addresses per base field code
	// ------------------------------------------------------------
	localparam logic [CFG_W-1:0] DEFAULT_CFG = 32'h0000_0000;
	localparam logic [BASE_W-1:0] BASE_CODE0 = 16'h0000;
	localparam logic [BASE_W-1:0] BASE_CODE1 = 16'h00F0;
	localparam logic [BASE_W-1:0] BASE_CODE2 = 16'h0F00;
	localparam logic [BASE_W-1:0] BASE_CODE3 = 16'hFF00;

	// ------------------------------------------------------------
	// Sampling depth
	// ------------------------------------------------------------
	localparam int SAMPLE_EDGES = 2;

endpackage

`default_nettype wire

// File: core/rcs_capture.sv
// Two-deep sample register for the configuration word and select bit.
// Assumes en_i is high on every clock edge that falls inside hard reset.
`default_nettype none

module rcs_capture #(
	parameter int W = 33
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Sample stream
	input wire logic en_i,
	input wire logic [W-1:0] d_i,
	// Last two samples
	output logic [W-1:0] last_o,
	output logic [W-1:0] prev_o
);

	if (W < 2) begin : g_bad_width
		$error("rcs_capture: a sample needs the select bit and at least one data bit");
	end

	// Each enabled edge pushes the newest sample and keeps the one before it.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			last_o <= '0;
			prev_o <= '0;
		end else if (en_i) begin
			last_o <= d_i;
			prev_o <= last_o;
		end
	end

endmodule

`default_nettype wire

// File: verif/rcs_board_model.sv
// Board-side source of the startup configuration word on the data bus.
// Assumes the bench supplies the word and the hard reset level on mclk_i.
`default_nettype none
module rcs_board_model (
	// Clock and framing
	input wire logic mclk_i,
	input wire logic hard_reset_input_n_i,
	// Word to present
	input wire logic [31:0] word_i,
	// Data bus
	output wire logic [31:0] data_bus_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] idle_reg = 32'h5A5A_C3C3;
	// Out of hard reset the bus carries other traffic, so the word is gone.
	always_ff @(posedge mclk_i) begin
		idle_reg <= ~idle_reg;
	end
	assign data_bus_o = hard_reset_input_n_i ? idle_reg : word_i;
endmodule
`default_nettype wire

// File: verif/tb_reset_config_sampler.sv
// Self-checking bench for the reset configuration sampler.
// Assumes the board model presents the word on the data bus only inside hard reset.
`default_nettype none
module tb_reset_config_sampler;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] DEF = rcs_pkg::DEFAULT_CFG;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic hr_n = 1'b0;
	logic sel_n = 1'b0;
	logic wr = 1'b0;
	logic [15:0] wdata = 16'h0000;
	logic [31:0] word = 32'h0000_0000;
	wire logic [31:0] bus;
	wire logic [24:0] seen;
	int failures = 0;
	int checked = 0;
	rcs_board_model board (.mclk_i(mclk_i), .hard_reset_input_n_i(hr_n), .word_i(word),
		.data_bus_o(bus));
	rcs_sampler dut (.mclk_i(mclk_i), .rst_i(rst_i), .hard_reset_input_n_i(hr_n),
		.reset_config_select_n_i(sel_n), .data_bus_i(bus), .map_base_wr_i(wr),
		.map_base_wdata_i(wdata), .cfg_valid_o(seen[24]), .cfg_mismatch_o(seen[23]),
		.arb_internal_o(seen[22]), .irq_prefix_o(seen[21]), .mc_disable_o(seen[20]),
		.gpcs_enable_o(seen[19]), .boot_chip_select_en_o(seen[18]),
		.boot_port_size_o(seen[17:16]), .internal_map_base_o(seen[15:0]));
	initial begin
		forever #2 mclk_i = ~mclk_i;
	end
	function automatic logic [15:0] exp_base(input logic [1:0] code);
		case (code)
			2'h0: return rcs_pkg::BASE_CODE0;
			2'h1: return rcs_pkg::BASE_CODE1;
			2'h2: return rcs_pkg::BASE_CODE2;
			default: return rcs_pkg::BASE_CODE3;
		endcase
	endfunction
	function automatic logic [24:0] exp_out(input logic [31:0] w, input logic m);
		return {1'b1, m, w[31:29], ~w[29], ~w[29], w[28:27], exp_base(w[26:25])};
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("Checks made: %0d, mismatches: %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Hard reset with word a, then b on the final edge; checks after release.
	task automatic hard_cycle(input logic [31:0] a, input logic [31:0] b, input logic s);
		logic [24:0] e;
		e = exp_out(s ? DEF : b, a !== b);
		@(posedge mclk_i);
		hr_n <= 1'b0;
		word <= a;
		sel_n <= s;
		repeat (3) @(posedge mclk_i);
		word <= b;
		#1;
		check({29'h0, seen[24], seen[19:18]}, 32'h0);
		@(posedge mclk_i);
		hr_n <= 1'b1;
		@(posedge mclk_i);
		sel_n <= ~s;
		#1;
		check({7'h0, seen}, {7'h0, e});
		repeat (5) @(posedge mclk_i);
		#1;
		check({7'h0, seen}, {7'h0, e});
	endtask
	task automatic test_bus_words();
		logic [31:0] w;
		for (int i = 0; i < 4; i++) begin
			w = {i[1:0] ^ 2'h1, i[0], i[1:0], i[1:0], 25'h1A5A5A5};
			hard_cycle(w, w, 1'b0);
		end
	endtask
	task automatic test_default_word();
		hard_cycle(32'hFFFF_FFFF, 32'hFFFF_FFFF, 1'b1);
	endtask
	task automatic test_unstable_word();
		hard_cycle(32'h1234_5678, 32'hA5C3_3C5A, 1'b0);
	endtask
	task automatic test_map_base_write();
		@(posedge mclk_i);
		wr <= 1'b1;
		wdata <= 16'h1234;
		@(posedge mclk_i);
		wdata <= 16'hBEEF;
		#1;
		check({16'h0, seen[15:0]}, 32'h0000_1234);
		@(posedge mclk_i);
		wr <= 1'b0;
		hr_n <= 1'b0;
		#1;
		check({16'h0, seen[15:0]}, 32'h0000_BEEF);
		@(posedge mclk_i);
		wr <= 1'b1;
		wdata <= 16'h0F0F;
		@(posedge mclk_i);
		wr <= 1'b0;
		#1;
		check({16'h0, seen[15:0]}, 32'h0000_BEEF);
	endtask
	// Power-on reset release with hard reset still low: nothing valid, base at default.
	task automatic test_power_on();
		logic [31:0] e;
		e = {16'h0, exp_base(DEF[26:25])};
		@(posedge mclk_i);
		#1;
		check({13'h0, seen[24], seen[19:18], seen[15:0]}, e);
	endtask
	initial begin
		repeat (16) @(posedge mclk_i);
		rst_i <= 1'b0;
		test_power_on();
		test_bus_words();
		test_map_base_write();
		test_default_word();
		test_unstable_word();
		final_report();
	end
	initial begin
		repeat (1000) @(posedge mclk_i);
		failures++;
		final_report();
	end
endmodule
`default_nettype wire
